// File: hdl/obj_status_pkg.sv
// constants and types for the message object status and tag block
// Behaviour
// RL1 - set length warning on code mismatch
// RL2 - received length code overwrites object code
// RL3 - set transmit complete on successful send
// RL4 - lowest enabled object index transmits first
// RL5 - set receive complete on successful reception
// RL6 - lowest matching object index updated first
// RL7 - bit error only while transmitting mismatch
// RL8 - no bit error in arbitration, ack, error
// RL9 - stuff error over five equal bits
// RL10 - crc mismatch sets checksum fail flag
// RL11 - delimiter or frame end violation form error
// RL12 - no dominant ack slot sets ack flag
// RL13 - flags stick until software clears them
// RL14 - status register readable at address b2
// RL15 - standard id split across tag bytes
// RL16 - standard byte three reserved, byte four tags
// RL17 - extended id bits in tag bytes one-three
// RL18 - extended byte four id, rtr, rb1, rb0
// RL19 - software writes reserved bits as zero
// RL20 - tag bytes not reset, undefined until written
// RL21 - format bit selects standard or extended layout
// RL22 - page object number selects presented object
// RL23 - form error cleared only by software
package obj_status_pkg;
  localparam logic [7:0] ADDR_PAGE = 8'h00_B1;
  localparam logic [7:0] ADDR_STATUS = 8'h00_B2;
  localparam logic [7:0] ADDR_CONTROL = 8'h00_B3;
  localparam logic [7:0] ADDR_TAG1 = 8'h00_BC;
  localparam logic [7:0] ADDR_TAG2 = 8'h00_BD;
  localparam logic [7:0] ADDR_TAG3 = 8'h00_BE;
  localparam logic [7:0] ADDR_TAG4 = 8'h00_BF;
  localparam int BIT_LEN_WARN = 7;
  localparam int BIT_TX_DONE = 6;
  localparam int BIT_RX_DONE = 5;
  localparam int BIT_BIT_ERR = 4;
  localparam int BIT_STUFF_ERR = 3;
  localparam int BIT_CRC_ERR = 2;
  localparam int BIT_FORM_ERR = 1;
  localparam int BIT_ACK_ERR = 0;
  localparam int PAGE_OBJ_LSB = 4;
  localparam int CTRL_EXT_BIT = 4;
  localparam int NUM_OBJECTS = 15;
  localparam logic [7:0] RESET_PAGE = 8'h00_00;
  localparam logic [7:0] RESET_STATUS = 8'h00_00;
  localparam logic [7:0] RESET_CONTROL = 8'h00_00;
  localparam logic [7:0] STD_TAG2_MASK = 8'h00_E0;
  localparam logic [7:0] STD_TAG4_MASK = 8'h00_05;
  typedef enum logic [1:0]
  {
    ev_tx_done = 2'b00,
    ev_rx_done = 2'b01,
    ev_error = 2'b11
  } event_kind_t;
endpackage

// File: hdl/obj_event_if.sv
// event report carried from arbitration to the status store
`timescale 1ns/1ps
`default_nettype none
interface obj_event_if;
  logic valid;
  logic [3:0] obj;
  logic [7:0] set_bits;
  logic dlc_load;
  logic [3:0] data_length_code;
  modport src (output valid, output obj, output set_bits, output dlc_load, output data_length_code);
  modport dst (input valid, input obj, input set_bits, input dlc_load, input data_length_code);
endinterface
`default_nettype wire

// File: hdl/obj_event_arb.sv
// selects the lowest indexed object among simultaneous hits and builds its flag set
`timescale 1ns/1ps
`default_nettype none
module obj_event_arb
  import obj_status_pkg::*;
#(
  parameter int N = NUM_OBJECTS
)
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_tx_done,
  input wire logic [N-1:0] i_tx_enabled,
  input wire logic i_rx_done,
  input wire logic [N-1:0] i_rx_hits,
  input wire logic [3:0] i_rx_dlc,
  input wire logic [N*4-1:0] i_cfg_dlc,
  input wire logic i_err_valid,
  input wire logic [3:0] i_err_obj,
  input wire logic [4:0] i_err_bits,
  obj_event_if.src ev
);
  // the object number is four bits wide, so more than sixteen objects cannot be told apart
  if (N < 1 || N > 16)
  begin : g_bad_count
    $error("object count out of range");
  end

  function automatic logic [3:0] lowest(input logic [N-1:0] v);
    lowest = 4'h0_0;
    for (int k = N - 1; k >= 0; k--)
      if (v[k])
        lowest = 4'(k);
  endfunction

  wire logic [3:0] tx_obj = lowest(i_tx_enabled); // [RL4]
  wire logic [3:0] rx_obj = lowest(i_rx_hits); // [RL6]
  wire logic [3:0] cfg_dlc = i_cfg_dlc[rx_obj*4 +: 4];
  wire logic rx_ok = i_rx_done && (|i_rx_hits);
  wire logic tx_ok = i_tx_done && (|i_tx_enabled);
  wire logic dlc_warn = rx_ok && (cfg_dlc != i_rx_dlc); // [RL1]

  // errors win the slot; a frame cannot complete and fail in one cycle
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ev.valid <= 1'b0;
      ev.obj <= 4'h0_0;
      ev.set_bits <= 8'h00_00;
      ev.dlc_load <= 1'b0;
      ev.data_length_code <= 4'h0_0;
    end
    else
    begin
      ev.valid <= i_err_valid || rx_ok || tx_ok;
      ev.obj <= i_err_valid ? i_err_obj : (rx_ok ? rx_obj : tx_obj);
      ev.set_bits <= i_err_valid ? {3'b000, i_err_bits} :
        {dlc_warn, tx_ok && !rx_ok, rx_ok, 5'b00000}; // [RL3] [RL5]
      ev.dlc_load <= !i_err_valid && rx_ok; // [RL2]
      ev.data_length_code <= i_rx_dlc;
    end
  end
endmodule
`default_nettype wire

// File: hdl/obj_status_tags.sv
// per-object status flags, tag bytes and control bytes behind the special-function bus
`timescale 1ns/1ps
`default_nettype none
module obj_status_tags
  import obj_status_pkg::*;
#(
  parameter int N = NUM_OBJECTS
)
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  output logic [7:0] o_sfr_rdata,
  input wire logic i_tx_done,
  input wire logic [N-1:0] i_tx_enabled,
  input wire logic i_rx_done,
  input wire logic [N-1:0] i_rx_hits,
  input wire logic [3:0] i_rx_dlc,
  input wire logic i_bit_tx,
  input wire logic i_bit_mon,
  input wire logic i_bit_sample,
  input wire logic i_transmitting,
  input wire logic i_in_arbitration,
  input wire logic i_in_ack_slot,
  input wire logic i_sending_error,
  input wire logic i_stuff_viol,
  input wire logic i_crc_mismatch,
  input wire logic i_form_viol,
  input wire logic i_ack_missing,
  input wire logic [3:0] i_err_obj,
  output logic [N-1:0] o_flag_pending,
  output logic o_ext_format
);
  if (N < 1 || N > 16)
  begin : g_bad_count
    $error("object count out of range");
  end

  logic [7:0] page_r;
  logic [7:0] status_r [N];
  logic [7:0] control_r [N];
  logic [7:0] tag_r [N][4];

  wire logic [3:0] sel = page_r[PAGE_OBJ_LSB +: 4]; // [RL22]
  wire logic sel_ok = (int'(sel) < N);
  // an unpopulated object number shows standard format instead of an undefined level
  wire logic ext = sel_ok && control_r[sel][CTRL_EXT_BIT]; // [RL21]
  wire logic sample_mismatch = i_bit_sample && i_transmitting && (i_bit_tx != i_bit_mon);
  // arbitration loss and the ack slot are legal mismatches, as is bus dominance in an error frame
  wire logic bit_err = sample_mismatch && !i_in_arbitration && !i_in_ack_slot
    && !i_sending_error; // [RL7] [RL8]
  wire logic [4:0] err_bits = {bit_err, i_stuff_viol, i_crc_mismatch, i_form_viol,
    i_ack_missing}; // [RL9] [RL10] [RL11] [RL12]
  wire logic [N*4-1:0] cfg_dlc;
  wire logic wr_page = i_sfr_wr && i_sfr_addr == ADDR_PAGE;
  wire logic wr_status = i_sfr_wr && i_sfr_addr == ADDR_STATUS && sel_ok;
  wire logic wr_control = i_sfr_wr && i_sfr_addr == ADDR_CONTROL && sel_ok;
  wire logic wr_tag = i_sfr_wr && i_sfr_addr[7:2] == ADDR_TAG1[7:2] && sel_ok;
  wire logic [1:0] tag_idx = i_sfr_addr[1:0];
  wire logic [7:0] tag_view = tag_r[sel][tag_idx];
  // reserved bits read back as zero in standard layout so software never sees stale extended data
  wire logic [7:0] tag_shown = ext ? tag_view :
    (tag_idx == 2'd1) ? (tag_view & STD_TAG2_MASK) :
    (tag_idx == 2'd2) ? 8'h00_00 :
    (tag_idx == 2'd3) ? (tag_view & STD_TAG4_MASK) : tag_view; // [RL15] [RL16] [RL17] [RL18]
  wire logic [7:0] rd_mux =
    (i_sfr_addr == ADDR_PAGE) ? page_r :
    (!sel_ok) ? 8'h00_00 :
    (i_sfr_addr == ADDR_STATUS) ? status_r[sel] : // [RL14]
    (i_sfr_addr == ADDR_CONTROL) ? control_r[sel] :
    (i_sfr_addr[7:2] == ADDR_TAG1[7:2]) ? tag_shown : 8'h00_00;

  obj_event_if evb ();

  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_dlc
      assign cfg_dlc[g*4 +: 4] = control_r[g][3:0];
    end
  endgenerate

  obj_event_arb #(.N(N)) u_arb (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_tx_done(i_tx_done),
    .i_tx_enabled(i_tx_enabled),
    .i_rx_done(i_rx_done),
    .i_rx_hits(i_rx_hits),
    .i_rx_dlc(i_rx_dlc),
    .i_cfg_dlc(cfg_dlc),
    .i_err_valid(|err_bits),
    .i_err_obj(i_err_obj),
    .i_err_bits(err_bits),
    .ev(evb)
  );

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      page_r <= RESET_PAGE;
    else if (wr_page)
      page_r <= i_sfr_wdata;
  end

  // status: software writes zero to clear a bit; a same-cycle hardware set wins
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      for (int k = 0; k < N; k++)
      begin
        status_r[k] <= RESET_STATUS;
        control_r[k] <= RESET_CONTROL;
      end
    end
    else
    begin
      for (int k = 0; k < N; k++)
      begin
        logic [7:0] s;
        logic [7:0] c;
        s = status_r[k];
        c = control_r[k];
        if (wr_status && int'(sel) == k)
          s = s & i_sfr_wdata; // [RL13] [RL23]
        if (wr_control && int'(sel) == k)
          c = i_sfr_wdata;
        if (evb.valid && int'(evb.obj) == k)
        begin
          s = s | evb.set_bits; // [RL13]
          if (evb.dlc_load)
            c[3:0] = evb.data_length_code; // [RL2]
        end
        status_r[k] <= s;
        control_r[k] <= c;
      end
    end
  end

  // tag bytes deliberately carry no reset
  always_ff @(posedge i_clk)
  begin
    if (wr_tag)
      tag_r[sel][tag_idx] <= i_sfr_wdata; // [RL20]
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_sfr_rdata <= 8'h00_00;
      o_flag_pending <= '0;
      o_ext_format <= 1'b0;
    end
    else
    begin
      o_sfr_rdata <= i_sfr_rd ? rd_mux : 8'h00_00;
      for (int k = 0; k < N; k++)
        o_flag_pending[k] <= |status_r[k];
      o_ext_format <= ext;
    end
  end
endmodule
`default_nettype wire

// File: sim/can_bus_node.sv
// far-side model: frame outcomes reported by the bus engine
`timescale 1ns/1ps
`default_nettype none
module can_bus_node
  import obj_status_pkg::*;
(
  input wire logic i_clk,
  output logic [2:0] o_pulse = 3'h0,
  output logic [3:0] o_err = 4'h0,
  output logic [NUM_OBJECTS-1:0] o_vec = '0,
  output logic [3:0] o_code = 4'h0,
  output logic [5:0] o_ctx = 6'h00
);
  // pulses last one cycle; object lists and bit context stay as levels
  task automatic ev(input logic [2:0] p, input logic [3:0] e, input logic [NUM_OBJECTS-1:0] v,
    input logic [3:0] c, input logic [5:0] x);
    @(posedge i_clk);
    o_pulse <= p;
    o_err <= e;
    o_vec <= v;
    o_code <= c;
    o_ctx <= x;
    @(posedge i_clk);
    o_pulse <= 3'h0;
    o_err <= 4'h0;
    repeat (3) @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

// File: sim/obj_status_checker.sv
// port-level assertions for the object status and tag block
`timescale 1ns/1ps
`default_nettype none
module obj_status_checker
  import obj_status_pkg::*;
#(
  parameter int N = NUM_OBJECTS
)
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic i_tx_done,
  input wire logic [N-1:0] i_tx_enabled,
  input wire logic i_rx_done,
  input wire logic [N-1:0] i_rx_hits,
  input wire logic i_bit_tx,
  input wire logic i_bit_mon,
  input wire logic i_bit_sample,
  input wire logic i_transmitting,
  input wire logic i_in_arbitration,
  input wire logic i_in_ack_slot,
  input wire logic i_sending_error,
  input wire logic i_stuff_viol,
  input wire logic i_crc_mismatch,
  input wire logic i_form_viol,
  input wire logic i_ack_missing,
  input wire logic [3:0] i_err_obj,
  input wire logic [N-1:0] o_flag_pending,
  input wire logic o_ext_format
);
  logic [1:0] wr_d_r;
  logic [1:0] clr_d_r;
  logic [2:0] ev_d_r;
  logic mis;
  logic hold;
  logic errs;
  logic any_ev;
  logic mapped;
  logic [N-1:0] rx_low;
  logic [N-1:0] tx_low;
  logic [N-1:0] err_one;
  assign mis = i_bit_sample & i_transmitting & (i_bit_tx ^ i_bit_mon);
  assign hold = i_in_arbitration | i_in_ack_slot | i_sending_error;
  assign errs = i_stuff_viol | i_crc_mismatch | i_form_viol | i_ack_missing | (mis & ~hold);
  assign any_ev = errs | i_tx_done | i_rx_done;
  assign mapped = i_sfr_addr inside {ADDR_PAGE, ADDR_STATUS, ADDR_CONTROL, ADDR_TAG1, ADDR_TAG2,
    ADDR_TAG3, ADDR_TAG4};
  assign rx_low = i_rx_hits & (~i_rx_hits + 1'b1);
  assign tx_low = i_tx_enabled & (~i_tx_enabled + 1'b1);
  assign err_one = N'(1) << i_err_obj;
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      wr_d_r <= 2'h0;
      clr_d_r <= 2'h0;
      ev_d_r <= 3'h0;
    end
    else
    begin
      wr_d_r <= {wr_d_r[0], i_sfr_wr};
      clr_d_r <= {clr_d_r[0], i_sfr_wr && i_sfr_addr == ADDR_STATUS};
      ev_d_r <= {ev_d_r[1:0], any_ev};
    end
  end
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);
  AST_RDATA_IDLE: assert property (!$past(i_sfr_rd) |-> o_sfr_rdata == 8'h00)
    else $error("read data outside answer");
  AST_RDATA_UNMAPPED: assert property (i_sfr_rd && !mapped |=> o_sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  // event register, status store and pending register: the flag shows three edges on
  AST_RX_LOWEST: assert property (i_rx_done && |i_rx_hits && !errs |->
    ##3 (o_flag_pending & $past(rx_low, 3)) != '0) else $error("rx flag missing");
  AST_TX_LOWEST: assert property (i_tx_done && |i_tx_enabled && !i_rx_done
    && !errs |-> ##3 (o_flag_pending & $past(tx_low, 3)) != '0) else $error("tx flag missing");
  AST_ERR_SETS: assert property (errs && i_err_obj < N |->
    ##3 (o_flag_pending & $past(err_one, 3)) != '0) else $error("error flag missing");
  AST_PEND_STICKY: assert property (($past(o_flag_pending) & ~o_flag_pending) != '0 |->
    |clr_d_r) else $error("flag dropped without clear");
  AST_BIT_MISMATCH_FLAG_EXEMPT: assert property ((mis && hold && !any_ev && ev_d_r == 3'h0 &&
    o_flag_pending == '0) ##1 !any_ev ##1 !any_ev |-> ##1 o_flag_pending == '0)
    else $error("exempt mismatch flagged");
  AST_EXT_FORMAT: assert property ($changed(o_ext_format) |-> |wr_d_r)
    else $error("format bit moved alone");
  cover property (i_rx_done && |i_rx_hits);
  cover property (errs);
  cover property (i_tx_done && |i_tx_enabled);
  cover property (i_sfr_rd && i_sfr_addr == ADDR_STATUS);
endmodule
bind obj_status_tags obj_status_checker #(.N(N)) chk (.i_clk, .i_resetn, .i_sfr_addr,
  .i_sfr_wr, .i_sfr_rd, .o_sfr_rdata, .i_tx_done, .i_tx_enabled, .i_rx_done, .i_rx_hits,
  .i_bit_tx, .i_bit_mon, .i_bit_sample, .i_transmitting, .i_in_arbitration, .i_in_ack_slot,
  .i_sending_error, .i_stuff_viol, .i_crc_mismatch, .i_form_viol, .i_ack_missing, .i_err_obj,
  .o_flag_pending, .o_ext_format);
`default_nettype wire

// File: sim/can_object_status_and_id_tag_bench.sv
// self-checking bench for the object status and tag block
`timescale 1ns/1ps
`default_nettype none
module can_object_status_and_id_tag_bench;
  import obj_status_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [7:0] tv [4] = '{8'h5A, 8'hA5, 8'h3C, 8'hFB};
  logic [5:0] bx [6] = '{6'h2C, 6'h2A, 6'h29, 6'h20, 6'h38, 6'h28};
  logic [2:0] pl;
  logic [3:0] er;
  logic [3:0] cd;
  logic [5:0] cx;
  logic [NUM_OBJECTS-1:0] vc;
  logic [NUM_OBJECTS-1:0] pend;
  logic ext;
  int error_cnt = 0;
  int comparisons = 0;
  obj_status_tags uut (.i_clk(clk), .i_resetn(resetn), .i_sfr_addr(addr), .i_sfr_wdata(wdata),
    .i_sfr_wr(wr), .i_sfr_rd(rd), .o_sfr_rdata(rdata), .i_tx_done(pl[2]), .i_tx_enabled(vc),
    .i_rx_done(pl[1]), .i_rx_hits(vc), .i_rx_dlc(cd), .i_bit_tx(cx[5]), .i_bit_mon(cx[4]),
    .i_bit_sample(pl[0]), .i_transmitting(cx[3]), .i_in_arbitration(cx[2]),
    .i_in_ack_slot(cx[1]), .i_sending_error(cx[0]), .i_stuff_viol(er[3]),
    .i_crc_mismatch(er[2]), .i_form_viol(er[1]), .i_ack_missing(er[0]), .i_err_obj(cd),
    .o_flag_pending(pend), .o_ext_format(ext));
  can_bus_node node (.i_clk(clk), .o_pulse(pl), .o_err(er), .o_vec(vc), .o_code(cd), .o_ctx(cx));
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    cmp(rdata, exp);
  endtask
  task automatic sel(input logic [3:0] o, input logic [7:0] exp);
    wr_reg(ADDR_PAGE, {o, 4'h0});
    rd_reg(ADDR_STATUS, exp);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    forever #2 clk = ~clk;
  end
  // a full run needs well under two thousand cycles
  initial
  begin
    #20000;
    error_cnt++;
    results();
  end
  initial
  begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    rd_reg(ADDR_CONTROL, RESET_CONTROL);
    rd_reg(ADDR_STATUS, RESET_STATUS);
    wr_reg(ADDR_CONTROL, 8'h14);
    for (int i = 0; i < 4; i++)
      wr_reg(ADDR_TAG1 + 8'(i), tv[i]);
    for (int i = 0; i < 4; i++)
      rd_reg(ADDR_TAG1 + 8'(i), tv[i]);
    cmp({7'h00, ext}, 8'h01);
    wr_reg(ADDR_CONTROL, 8'h04);
    rd_reg(ADDR_TAG1, tv[0]);
    rd_reg(ADDR_TAG2, tv[1] & STD_TAG2_MASK);
    rd_reg(ADDR_TAG3, 8'h00);
    rd_reg(ADDR_TAG4, tv[3] & STD_TAG4_MASK);
    wr_reg(ADDR_TAG2, 8'hC0);
    rd_reg(ADDR_TAG2, 8'hC0);
    node.ev(3'h2, 4'h0, 15'h0005, 4'h8, 6'h00);
    sel(4'h0, 8'hA0);
    rd_reg(ADDR_CONTROL, 8'h08);
    cmp(pend[7:0], 8'h01);
    sel(4'h2, 8'h00);
    sel(4'h0, 8'hA0);
    wr_reg(ADDR_STATUS, 8'h7F);
    rd_reg(ADDR_STATUS, 8'h20);
    wr_reg(ADDR_STATUS, 8'h00);
    node.ev(3'h4, 4'h0, 15'h000A, 4'h0, 6'h00);
    sel(4'h3, 8'h00);
    sel(4'h1, 8'h40);
    wr_reg(ADDR_STATUS, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      node.ev(3'h0, 4'h8 >> i, 15'h0000, 4'h5, 6'h00);
      sel(4'h5, 8'h08 >> i);
      wr_reg(ADDR_STATUS, 8'h00);
    end
    // the clear is taken on the very edge at which the error reaches the store
    fork
      node.ev(3'h0, 4'h1, 15'h0000, 4'h5, 6'h00);
      begin
        @(posedge clk);
        wr_reg(ADDR_STATUS, 8'h00);
      end
    join
    rd_reg(ADDR_STATUS, 8'h01);
    wr_reg(ADDR_STATUS, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      node.ev(3'h1, 4'h0, 15'h0000, 4'h6, bx[i]);
      sel(4'h6, i == 5 ? 8'h10 : 8'h00);
    end
    wr_reg(ADDR_PAGE, 8'hF0);
    rd_reg(ADDR_STATUS, 8'h00);
    rd_reg(8'hB4, 8'h00);
    results();
  end
endmodule
`default_nettype wire
